// ---- bench/drive_plant_model.sv ----
`timescale 1ns/1ps

module drive_plant_model #(
    parameter int unsigned FREQ_TOP    = 200,
    parameter int unsigned PRESS_START = 2000
) (
    input  wire logic                     clock_in,
    input  wire logic                     arst_n_in,
    input  wire logic                     run_in,
    input  wire fill_ramp_pkg::pressure_t step_in,
    output fill_ramp_pkg::freq_t          freq_out,
    output fill_ramp_pkg::pressure_t      press_out
);
    import fill_ramp_pkg::*;
    // ====================
    // Speed follows run, pressure builds while pumping
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            freq_out <= 16'h0;
            press_out <= pressure_t'(PRESS_START);
        end else begin
            if (run_in && freq_out < freq_t'(FREQ_TOP))
                freq_out <= freq_out + 16'h1;
            else if (!run_in)
                freq_out <= 16'h0;
            if (run_in)
                press_out <= press_out + step_in;
        end
    end
endmodule : drive_plant_model

// ---- bench/fill_ramp_seq_props.sv ----
`timescale 1ns/1ps

module fill_ramp_seq_props (
    input wire logic                     clock_in,
    input wire logic                     arst_n_in,
    input wire logic                     reg_read_in,
    input wire fill_ramp_pkg::word_t     reg_rdata_out,
    input wire logic                     run_out,
    input wire logic                     ramp_initial_out,
    input wire fill_ramp_pkg::freq_t     ramp_time_out,
    input wire fill_ramp_pkg::pressure_t setpoint_out,
    input wire logic                     fill_active_out
);
    import fill_ramp_pkg::*;
    // ====================
    // Sequencer checks
    default clocking dc @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    property p_rdata_quiet;
        !$past(reg_read_in) |-> reg_rdata_out == 32'h0;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("read data outside answer cycle");
    property p_init_nonzero;
        ramp_initial_out |-> ramp_time_out != 16'h0;
    endproperty
    a_init_nonzero: assert property (p_init_nonzero)
        else $error("initial ramp with zero time");
    property p_init_bounded;
        ramp_initial_out |-> ramp_time_out <= 16'he10;
    endproperty
    a_init_bounded: assert property (p_init_bounded)
        else $error("initial ramp time above limit");
    property p_init_runs;
        ramp_initial_out |-> run_out && !fill_active_out;
    endproperty
    a_init_runs: assert property (p_init_runs)
        else $error("initial ramp outside acceleration");
    property p_fill_entry;
        $rose(fill_active_out) |-> run_out && $past(run_out);
    endproperty
    a_fill_entry: assert property (p_fill_entry)
        else $error("fill entered without acceleration");
    property p_fill_rising;
        fill_active_out[*4] |-> setpoint_out >= $past(setpoint_out);
    endproperty
    a_fill_rising: assert property (p_fill_rising)
        else $error("fill setpoint fell");
    property p_fill_step;
        fill_active_out[*4] |->
            setpoint_out - $past(setpoint_out) <= 32'hf4240;
    endproperty
    a_fill_step: assert property (p_fill_step)
        else $error("fill setpoint step too large");
    property p_idle_quiet;
        !run_out |-> !ramp_initial_out && !(fill_active_out && !$past(run_out));
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("fill or initial ramp while idle");

    c_init: cover property ($rose(ramp_initial_out));
    c_fill: cover property ($rose(fill_active_out));
    c_handover: cover property ($fell(fill_active_out) && run_out);
endmodule : fill_ramp_seq_props

bind startup_fill_ramp_sequencer fill_ramp_seq_props u_props (
    .clock_in, .arst_n_in, .reg_read_in, .reg_rdata_out, .run_out,
    .ramp_initial_out, .ramp_time_out, .setpoint_out, .fill_active_out
);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`include "fill_ramp_map.svh"

module tb;
    import fill_ramp_pkg::*;
    localparam int unsigned TICKS = 10;
    logic      clock_in  = 1'b0;
    logic      arst_n_in = 1'b0;
    addr_t     addr      = 8'h0;
    word_t     wdata     = 32'h0;
    logic      wr_s      = 1'b0;
    logic      rd_s      = 1'b0;
    logic      start     = 1'b0;
    pressure_t step      = 32'h0;
    word_t     seed      = 32'h10983;
    word_t     rdata;
    word_t     v;
    freq_t     freq;
    freq_t     rtime;
    pressure_t press;
    pressure_t sp;
    logic      run;
    logic      init_on;
    logic      fill_on;
    int        fails     = 0;
    int        tests_run = 0;

    always #10 clock_in = ~clock_in;

    startup_fill_ramp_sequencer #(.TICK_CYCLES(TICKS)) dut (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
        .reg_rdata_out(rdata), .start_in(start), .output_freq_in(freq),
        .feedback_in(press), .run_out(run), .ramp_initial_out(init_on),
        .ramp_time_out(rtime), .setpoint_out(sp), .fill_active_out(fill_on)
    );
    drive_plant_model plant (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .run_in(run),
        .step_in(step), .freq_out(freq), .press_out(press)
    );

    function automatic word_t lfsr_next(input word_t s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic word_t round10(input word_t x);
        return x - (x % 32'ha);
    endfunction : round10
    function automatic word_t status_exp(input int i);
        return {30'h0, i[0] & ~i[1] & i[2], 1'b0};
    endfunction : status_exp
    function automatic logic sig(input int w);
        return (w == 0) ? run : (w == 1) ? init_on :
               (w == 2) ? fill_on : (sp == 32'hbb8);
    endfunction : sig

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input word_t exp, input word_t got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input addr_t ad, input word_t d);
        @(posedge clock_in);
        addr <= ad;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock_in);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input addr_t ad, input word_t exp, input string what);
        @(posedge clock_in);
        addr <= ad;
        rd_s <= 1'b1;
        @(posedge clock_in);
        rd_s <= 1'b0;
        @(negedge clock_in);
        chk(what, exp, rdata);
    endtask : rd
    task automatic wait_on(input int w, input logic lvl, input int lim);
        for (int n = 0; n < lim && sig(w) !== lvl; n++) @(negedge clock_in);
        if (sig(w) !== lvl) begin
            fails++;
            $display("MISMATCH wait%0d exp %b seen timeout", w, lvl);
            summarize();
        end
    endtask : wait_on

    initial begin
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        // ====================
        // Register reset values, refusals, limits
        rd(`FR_ADDR_INIT_RAMP, 32'h0, "init_ramp");
        rd(`FR_ADDR_FILL_RATE, 32'h0, "fill_rate");
        rd(`FR_ADDR_NORM_RAMP, 32'h64, "norm_ramp");
        wr(`FR_ADDR_STATUS, 32'hffffffff);
        wr(8'h30, 32'hffffffff);
        rd(`FR_ADDR_STATUS, 32'h1, "status");
        rd(8'h30, 32'h0, "unmapped");
        wr(`FR_ADDR_INIT_RAMP, 32'hfff);
        rd(`FR_ADDR_INIT_RAMP, 32'he10, "init_clamp");
        wr(`FR_ADDR_FILL_RATE, 32'h3fffffff);
        rd(`FR_ADDR_FILL_RATE, 32'h3b9ac9ff, "rate_clamp");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            v = seed & 32'hfffff;
            wr(`FR_ADDR_FILLED_SP, v);
            rd(`FR_ADDR_FILLED_SP, round10(v), "filled_step");
        end
        for (int i = 0; i < 8; i++) begin
            wr(`FR_ADDR_CTRL, {30'h0, i[1], i[0]});
            wr(`FR_ADDR_FILL_RATE, {31'h0, i[2]});
            rd(`FR_ADDR_STATUS, status_exp(i), "fill_en");
        end
        $display("test registers done");
        // ====================
        // Open loop start, initial ramp off
        wr(`FR_ADDR_INIT_RAMP, 32'h0);
        wr(`FR_ADDR_CTRL, 32'h0);
        @(posedge clock_in);
        start <= 1'b1;
        wait_on(0, 1'b1, 10);
        chk("init_off", 32'h0, {31'h0, init_on});
        chk("ramp_time", 32'h64, {16'h0, rtime});
        repeat (300) @(negedge clock_in);
        chk("no_fill", 32'h0, {31'h0, fill_on});
        @(posedge clock_in);
        start <= 1'b0;
        wait_on(0, 1'b0, 10);
        $display("test open loop done");
        // ====================
        // Closed loop fill and handover
        wr(`FR_ADDR_INIT_RAMP, 32'h5);
        wr(`FR_ADDR_FB_FLOOR, 32'h3e8);
        wr(`FR_ADDR_REF_MAX, 32'h186a0);
        wr(`FR_ADDR_FILLED_SP, 32'hbb8);
        wr(`FR_ADDR_SETPOINT1, 32'hfa0);
        wr(`FR_ADDR_SETPOINT2, 32'h1b58);
        wr(`FR_ADDR_MIN_FREQ, 32'h32);
        wr(`FR_ADDR_FILL_RATE, 32'h1388);
        wr(`FR_ADDR_CTRL, 32'hd);
        @(posedge clock_in);
        start <= 1'b1;
        wait_on(0, 1'b1, 10);
        chk("init_on", 32'h1, {31'h0, init_on});
        chk("init_time", 32'h5, {16'h0, rtime});
        wait_on(1, 1'b0, 300);
        chk("min_freq", 32'h1, {31'h0, freq >= 16'h32});
        chk("norm_time", 32'h64, {16'h0, rtime});
        wait_on(2, 1'b1, 10);
        repeat (2) @(negedge clock_in);
        chk("sp_load", 32'h1, {31'h0, sp - 32'h7d0 < 32'h6});
        v = sp;
        repeat (10 * TICKS) @(negedge clock_in);
        chk("fill_slope", 32'h32, sp - v);
        wait_on(3, 1'b1, 3000);
        repeat (50) @(negedge clock_in);
        chk("sp_limit", 32'hbb8, sp);
        chk("still_fill", 32'h1, {31'h0, fill_on});
        @(posedge clock_in);
        step <= 32'h1;
        wait_on(2, 1'b0, 1100);
        repeat (2) @(negedge clock_in);
        chk("handover", 32'h1b58, sp);
        chk("run_after", 32'h1, {31'h0, run});
        $display("test fill done");
        // ====================
        // Ramped stop
        @(posedge clock_in);
        start <= 1'b0;
        step <= 32'h0;
        repeat (100) @(negedge clock_in);
        chk("stop_run", 32'h1, {31'h0, run});
        chk("stop_ramp", 32'h1, {31'h0, sp - 32'h1b01 < 32'h57});
        wait_on(0, 1'b0, 20000);
        $display("test stop done");
        summarize();
    end
endmodule : tb

// ---- hdl/fill_ramp_map.svh ----
`ifndef FILL_RAMP_MAP_SVH
`define FILL_RAMP_MAP_SVH

// ============================================================
// Register offsets (byte addresses)
`define FR_ADDR_CTRL        8'h00
`define FR_ADDR_INIT_RAMP   8'h04
`define FR_ADDR_NORM_RAMP   8'h08
`define FR_ADDR_FILL_RATE   8'h0c
`define FR_ADDR_FILLED_SP   8'h10
`define FR_ADDR_FB_FLOOR    8'h14
`define FR_ADDR_REF_MAX     8'h18
`define FR_ADDR_SETPOINT1   8'h1c
`define FR_ADDR_SETPOINT2   8'h20
`define FR_ADDR_MIN_FREQ    8'h24
`define FR_ADDR_STATUS      8'h28
`define FR_ADDR_ACTIVE_SP   8'h2c

// ============================================================
// Control fields
`define FR_CTRL_CLOSED_BIT  0
`define FR_CTRL_INVERSE_BIT 1
`define FR_CTRL_SP_SEL_BIT  2
`define FR_CTRL_STOPFILL_BIT 3
`define FR_CTRL_WIDTH       4

// ============================================================
// Status fields
`define FR_STAT_INIT_OFF_BIT 0
`define FR_STAT_FILL_EN_BIT  1
`define FR_STAT_STATE_LSB    4

// ============================================================
// Limits and scaling
`define FR_INIT_MAX         12'he10
`define FR_FILL_RATE_MAX    30'h3b9ac9ff
`define FR_CENTI_IN_MILLI   32'h0000000a
`define FR_MILLI_PER_UNIT   31'h000003e8

// ============================================================
// Reset values
`define FR_RST_CTRL         4'h0
`define FR_RST_INIT_RAMP    12'h000
`define FR_RST_NORM_RAMP    16'h0064
`define FR_RST_FILL_RATE    30'h00000000
`define FR_RST_PRESSURE     32'h00000000
`define FR_RST_MIN_FREQ     16'h0000

// ============================================================
// Timing
`define FR_CLK_MHZ          50
`define FR_TICK_TIME_US     1000

`endif

// ---- hdl/fill_ramp_pkg.sv ----
package fill_ramp_pkg;

    typedef logic [31:0] pressure_t;
    typedef logic [29:0] rate_t;
    typedef logic [15:0] freq_t;
    typedef logic [7:0]  addr_t;
    typedef logic [31:0] word_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ACCEL = 3'h1,
        ST_FILL  = 3'h3,
        ST_RUN   = 3'h2,
        ST_STOP  = 3'h6
    } fill_state_t;

endpackage : fill_ramp_pkg

// ---- hdl/ramp_step_if.sv ----
`timescale 1ns/1ps

interface ramp_step_if;
    import fill_ramp_pkg::*;

    logic      load;
    pressure_t load_value;
    logic      move;
    pressure_t target;
    rate_t     rate;
    pressure_t setpoint;
    logic      at_target;

    modport ctrl (
        output load,
        output load_value,
        output move,
        output target,
        output rate,
        input  setpoint,
        input  at_target
    );

    modport stepper (
        input  load,
        input  load_value,
        input  move,
        input  target,
        input  rate,
        output setpoint,
        output at_target
    );

endinterface : ramp_step_if

// ---- hdl/ramp_stepper.sv ----
`timescale 1ns/1ps
`include "fill_ramp_map.svh"

module ramp_stepper (
    input  wire logic    clock_in,
    input  wire logic    arst_n_in,
    ramp_step_if.stepper step
);
    import fill_ramp_pkg::*;

    pressure_t   sp_reg;
    logic [9:0]  frac_reg;
    logic [30:0] total;
    logic [31:0] whole;
    logic [9:0]  rest;
    pressure_t   gap_up;
    pressure_t   gap_down;

    // ============================================================
    // Milli-units per second to milli-units per 1 ms tick
    function automatic logic [31:0] per_tick(input logic [30:0] t);
        per_tick = {1'b0, t / `FR_MILLI_PER_UNIT};
    endfunction : per_tick

    assign total    = {1'b0, step.rate} + {21'h000000, frac_reg};
    assign whole    = per_tick(total);
    assign rest     = 10'(total % `FR_MILLI_PER_UNIT);
    assign gap_up   = step.target - sp_reg;
    assign gap_down = sp_reg - step.target;

    // ============================================================
    // Setpoint moves toward target, saturating on it
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sp_reg   <= `FR_RST_PRESSURE;
            frac_reg <= 10'h000;
        end else if (step.load) begin
            sp_reg   <= step.load_value;
            frac_reg <= 10'h000;
        end else if (step.move) begin
            frac_reg <= rest;
            if (sp_reg < step.target) begin
                sp_reg <= (gap_up <= whole) ? step.target
                                            : sp_reg + whole;
            end else if (sp_reg > step.target) begin
                sp_reg <= (gap_down <= whole) ? step.target
                                              : sp_reg - whole;
            end
        end
    end

    assign step.setpoint  = sp_reg;
    assign step.at_target = (sp_reg == step.target);

endmodule : ramp_stepper

// ---- hdl/startup_fill_ramp_sequencer.sv ----
// Functional notes
// - Initial ramp rate until minimum speed, then normal ramp-up rate.
// - Initial ramp time 0.1 s to 360.0 s in 0.1 s steps.
// - Initial ramp time zero means off; only normal ramp-up applies.
// - Fill only in closed loop, nonzero fill rate, normal action.
// - Fill starts only after output reaches minimum frequency.
// - At minimum speed sample feedback, ramp setpoint toward filled limit.
// - Filled pressure is an upper setpoint limit during fill.
// - Fill rate counts process milli-units per second.
// - Feedback at filled limit hands over to setpoint one or two.
// - Fill rate 0.001 to 999999.999 units/s in .001 steps, default off.
// - Filled limit between feedback floor and reference max, .01 steps.
// - Fill ramping may also apply while stopping.
`timescale 1ns/1ps
`include "fill_ramp_map.svh"

module startup_fill_ramp_sequencer #(
    parameter int unsigned TICK_CYCLES = `FR_TICK_TIME_US * `FR_CLK_MHZ
) (
    input  wire logic                   clock_in,
    input  wire logic                   arst_n_in,
    input  wire fill_ramp_pkg::addr_t   reg_addr_in,
    input  wire fill_ramp_pkg::word_t   reg_wdata_in,
    input  wire logic                   reg_write_in,
    input  wire logic                   reg_read_in,
    output      fill_ramp_pkg::word_t   reg_rdata_out,
    input  wire logic                   start_in,
    input  wire fill_ramp_pkg::freq_t   output_freq_in,
    input  wire fill_ramp_pkg::pressure_t feedback_in,
    output      logic                   run_out,
    output      logic                   ramp_initial_out,
    output      fill_ramp_pkg::freq_t   ramp_time_out,
    output      fill_ramp_pkg::pressure_t setpoint_out,
    output      logic                   fill_active_out
);
    import fill_ramp_pkg::*;

    // ============================================================
    // Register file
    logic [3:0]  ctrl_reg;
    logic [11:0] init_ramp_reg;
    freq_t       norm_ramp_reg;
    rate_t       fill_rate_reg;
    pressure_t   filled_sp_reg;
    pressure_t   floor_reg;
    pressure_t   ref_max_reg;
    pressure_t   setpoint1_reg;
    pressure_t   setpoint2_reg;
    freq_t       min_freq_reg;
    word_t       rdata_reg;
    word_t       rdata_next;

    // ============================================================
    // Input synchronisers
    logic        start_meta_reg;
    logic        start_sync_reg;
    freq_t       freq_meta_reg;
    freq_t       freq_sync_reg;
    pressure_t   fb_meta_reg;
    pressure_t   fb_sync_reg;

    // ============================================================
    // Sequencer state
    fill_state_t state_reg;
    fill_state_t state_next;
    logic [15:0] tick_cnt_reg;
    logic        tick;
    logic        run_reg;
    logic        ramp_initial_reg;
    freq_t       ramp_time_reg;
    pressure_t   setpoint_reg;
    logic        fill_active_reg;

    ramp_step_if step ();

    // ============================================================
    // Helpers
    function automatic logic [31:0] clamp_hi(input logic [31:0] v,
                                            input logic [31:0] hi);
        clamp_hi = (v > hi) ? hi : v;
    endfunction : clamp_hi

    function automatic pressure_t to_centi(input pressure_t v);
        to_centi = 32'((v / `FR_CENTI_IN_MILLI) * `FR_CENTI_IN_MILLI);
    endfunction : to_centi

    // ============================================================
    // Decoding
    wire sel_ctrl   = (reg_addr_in == `FR_ADDR_CTRL);
    wire sel_init   = (reg_addr_in == `FR_ADDR_INIT_RAMP);
    wire sel_norm   = (reg_addr_in == `FR_ADDR_NORM_RAMP);
    wire sel_rate   = (reg_addr_in == `FR_ADDR_FILL_RATE);
    wire sel_filled = (reg_addr_in == `FR_ADDR_FILLED_SP);
    wire sel_floor  = (reg_addr_in == `FR_ADDR_FB_FLOOR);
    wire sel_refmax = (reg_addr_in == `FR_ADDR_REF_MAX);
    wire sel_sp1    = (reg_addr_in == `FR_ADDR_SETPOINT1);
    wire sel_sp2    = (reg_addr_in == `FR_ADDR_SETPOINT2);
    wire sel_minf   = (reg_addr_in == `FR_ADDR_MIN_FREQ);
    wire sel_status = (reg_addr_in == `FR_ADDR_STATUS);
    wire sel_active = (reg_addr_in == `FR_ADDR_ACTIVE_SP);

    wire closed_loop = ctrl_reg[`FR_CTRL_CLOSED_BIT];
    wire inverse_act = ctrl_reg[`FR_CTRL_INVERSE_BIT];
    wire sp_select   = ctrl_reg[`FR_CTRL_SP_SEL_BIT];
    wire stop_fill   = ctrl_reg[`FR_CTRL_STOPFILL_BIT];

    wire init_off     = (init_ramp_reg == 12'h000);
    wire fill_enabled = closed_loop && (fill_rate_reg != 30'h0)
                        && !inverse_act;
    wire at_min_speed = (freq_sync_reg >= min_freq_reg);

    // Filled limit kept inside floor..reference max
    wire pressure_t filled_lo  = (filled_sp_reg < floor_reg) ? floor_reg
                                                             : filled_sp_reg;
    wire pressure_t filled_eff = clamp_hi(filled_lo, ref_max_reg);
    wire pressure_t operating  = sp_select ? setpoint2_reg
                                           : setpoint1_reg;
    wire filled_reached = (fb_sync_reg >= filled_eff);
    wire stop_ramp = stop_fill && fill_enabled;

    wire [11:0] init_wr = 12'(clamp_hi(32'(reg_wdata_in[11:0]),
                                       32'(`FR_INIT_MAX)));
    wire rate_t rate_wr = 30'(clamp_hi({2'b00, reg_wdata_in[29:0]},
                                       32'(`FR_FILL_RATE_MAX)));

    // ============================================================
    // Register writes
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_reg      <= `FR_RST_CTRL;
            init_ramp_reg <= `FR_RST_INIT_RAMP;
            norm_ramp_reg <= `FR_RST_NORM_RAMP;
            fill_rate_reg <= `FR_RST_FILL_RATE;
            filled_sp_reg <= `FR_RST_PRESSURE;
            floor_reg     <= `FR_RST_PRESSURE;
            ref_max_reg   <= `FR_RST_PRESSURE;
            setpoint1_reg <= `FR_RST_PRESSURE;
            setpoint2_reg <= `FR_RST_PRESSURE;
            min_freq_reg  <= `FR_RST_MIN_FREQ;
        end else if (reg_write_in) begin
            if (sel_ctrl) begin
                ctrl_reg <= reg_wdata_in[`FR_CTRL_WIDTH-1:0];
            end else if (sel_init) begin
                init_ramp_reg <= init_wr;
            end else if (sel_norm) begin
                norm_ramp_reg <= reg_wdata_in[15:0];
            end else if (sel_rate) begin
                fill_rate_reg <= rate_wr;
            end else if (sel_filled) begin
                filled_sp_reg <= to_centi(reg_wdata_in);
            end else if (sel_floor) begin
                floor_reg <= reg_wdata_in;
            end else if (sel_refmax) begin
                ref_max_reg <= reg_wdata_in;
            end else if (sel_sp1) begin
                setpoint1_reg <= reg_wdata_in;
            end else if (sel_sp2) begin
                setpoint2_reg <= reg_wdata_in;
            end else if (sel_minf) begin
                min_freq_reg <= reg_wdata_in[15:0];
            end
        end
    end

    // ============================================================
    // Register reads
    always_comb begin
        rdata_next = 32'h00000000;
        if (!reg_read_in) begin
            rdata_next = 32'h00000000;
        end else if (sel_ctrl) begin
            rdata_next = {28'h0000000, ctrl_reg};
        end else if (sel_init) begin
            rdata_next = {20'h00000, init_ramp_reg};
        end else if (sel_norm) begin
            rdata_next = {16'h0000, norm_ramp_reg};
        end else if (sel_rate) begin
            rdata_next = {2'b00, fill_rate_reg};
        end else if (sel_filled) begin
            rdata_next = filled_sp_reg;
        end else if (sel_floor) begin
            rdata_next = floor_reg;
        end else if (sel_refmax) begin
            rdata_next = ref_max_reg;
        end else if (sel_sp1) begin
            rdata_next = setpoint1_reg;
        end else if (sel_sp2) begin
            rdata_next = setpoint2_reg;
        end else if (sel_minf) begin
            rdata_next = {16'h0000, min_freq_reg};
        end else if (sel_status) begin
            rdata_next = {25'h0000000, state_reg, 2'b00,
                          fill_enabled, init_off};
        end else if (sel_active) begin
            rdata_next = setpoint_reg;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ============================================================
    // Synchronisers
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_meta_reg <= 1'b0;
            start_sync_reg <= 1'b0;
            freq_meta_reg  <= 16'h0000;
            freq_sync_reg  <= 16'h0000;
            fb_meta_reg    <= 32'h00000000;
            fb_sync_reg    <= 32'h00000000;
        end else begin
            start_meta_reg <= start_in;
            start_sync_reg <= start_meta_reg;
            freq_meta_reg  <= output_freq_in;
            freq_sync_reg  <= freq_meta_reg;
            fb_meta_reg    <= feedback_in;
            fb_sync_reg    <= fb_meta_reg;
        end
    end

    // ============================================================
    // Control tick, one per millisecond
    assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
        end
    end

    // ============================================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_sync_reg) begin
                    state_next = ST_ACCEL;
                end
            end
            ST_ACCEL: begin
                if (!start_sync_reg) begin
                    state_next = ST_IDLE;
                end else if (at_min_speed) begin
                    state_next = fill_enabled ? ST_FILL : ST_RUN;
                end
            end
            ST_FILL: begin
                if (!start_sync_reg) begin
                    state_next = stop_ramp ? ST_STOP : ST_IDLE;
                end else if (filled_reached) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!start_sync_reg) begin
                    state_next = stop_ramp ? ST_STOP : ST_IDLE;
                end
            end
            ST_STOP: begin
                if (start_sync_reg) begin
                    state_next = ST_ACCEL;
                end else if (step.at_target) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Stepper hookup: sample feedback on fill entry
    assign step.load = ((state_reg == ST_ACCEL) && (state_next == ST_FILL))
                       || ((state_reg != ST_STOP)
                           && (state_next == ST_STOP));
    assign step.load_value = (state_next == ST_FILL) ? fb_sync_reg
                                                     : setpoint_reg;
    assign step.move   = tick && ((state_reg == ST_FILL)
                                  || (state_reg == ST_STOP));
    assign step.target = (state_reg == ST_STOP) ? floor_reg
                                                : filled_eff;
    assign step.rate   = fill_rate_reg;

    ramp_stepper u_stepper (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .step      (step.stepper)
    );

    wire accel_now = (state_next == ST_ACCEL);
    wire init_now  = accel_now && !init_off;
    wire pressure_t sp_now = ((state_reg == ST_FILL)
                              || (state_reg == ST_STOP))
                             ? step.setpoint : operating;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg        <= ST_IDLE;
            run_reg          <= 1'b0;
            ramp_initial_reg <= 1'b0;
            ramp_time_reg    <= `FR_RST_NORM_RAMP;
            setpoint_reg     <= `FR_RST_PRESSURE;
            fill_active_reg  <= 1'b0;
        end else begin
            state_reg        <= state_next;
            run_reg          <= (state_next != ST_IDLE);
            ramp_initial_reg <= init_now;
            ramp_time_reg    <= init_now ? {4'h0, init_ramp_reg}
                                         : norm_ramp_reg;
            setpoint_reg     <= sp_now;
            fill_active_reg  <= (state_reg == ST_FILL);
        end
    end

    assign reg_rdata_out    = rdata_reg;
    assign run_out          = run_reg;
    assign ramp_initial_out = ramp_initial_reg;
    assign ramp_time_out    = ramp_time_reg;
    assign setpoint_out     = setpoint_reg;
    assign fill_active_out  = fill_active_reg;

endmodule : startup_fill_ramp_sequencer
